// ===== design/pdp_line_sense.sv
// Purpose: Synchronise one line's comparators and classify it as open, Ra or Rd
// Assumes: Comparator thresholds already follow the advertised level
// Notes: Receive data is sampled once, comparators get two stages
`timescale 1ns/1ps
module pdp_line_sense
	import pdp_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Analog comparator levels
	input wire logic below_rd,
	input wire logic below_ra,
	input wire logic rx_raw,
	// Classified result
	output pdp_class_t line_class,
	output logic rx_level
);
	logic [1:0] meta;
	logic [1:0] stable;
	wire pdp_class_t decoded;

	// Ra pulls lower than Rd, so the Ra comparator takes precedence
	assign decoded = stable[1] ? CLS_RA : (stable[0] ? CLS_RD : CLS_OPEN);

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			meta <= 2'h0;
			stable <= 2'h0;
			line_class <= CLS_OPEN;
			rx_level <= 1'b0;
		end else begin
			meta <= {below_ra, below_rd};
			stable <= meta;
			line_class <= decoded;
			rx_level <= rx_raw;
		end
	end
endmodule

// ===== design/pdp_phy_attach.sv
// Purpose: Biphase mark PHY on the configuration lines plus source-side attach logic
// Assumes: Comparators report each line against the selected Ra and Rd thresholds
// Notes: Bits move one at a time over valid/ready; no software registers
//
// What this block does
// - Edge at every bit start, extra mid-bit edge for a one; decode alike.
// - Transmitted stream keeps running disparity within half a bit.
// - Preamble starts by driving the line low before the first edge.
// - Receiver decodes all but the first bit when the first preamble edge is missing.
// - One closing edge follows the last bit so the far end clocks it.
// - Driver enabled only while sending, otherwise high impedance.
// - Send and receive only on the orientation-selected line.
// - Only one party drives; never start sending while the line is busy.
// - Transmit peak level is a setting from application code.
// - Both lines open: watch both, keep VBUS and VCONN off.
// - Rd plus open: VBUS on, no VCONN, watch the Rd line.
// - Ra plus open: power off, watch open line for sink, Ra for detach.
// - Ra plus Rd: VBUS on, VCONN on Ra line, watch only Rd line.
// - Rd/Rd is debug accessory, Ra/Ra audio accessory; detach on either line.
// - Advertisement selectable among default, 1.5 A and 3 A pull-up currents.
// - Line below the Rd threshold of the chosen level means sink attached.
// - Line below the lower Ra threshold means an active cable needing VCONN.
// - Once connected, monitored line rising above Rd threshold means disconnect.
`timescale 1ns/1ps
module pdp_phy_attach
	import pdp_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Application settings
	input wire pdp_adv_t adv_level,
	input wire logic [PEAK_W-1:0] tx_peak_level,
	// Comparators and receive levels per line
	input wire logic line_a_below_rd,
	input wire logic line_a_below_ra,
	input wire logic line_a_rx,
	input wire logic line_b_below_rd,
	input wire logic line_b_below_ra,
	input wire logic line_b_rx,
	// Line drivers
	output logic config_line_a_o,
	output logic config_line_a_oe,
	output logic config_line_b_o,
	output logic config_line_b_oe,
	output logic [PEAK_W-1:0] tx_peak_level_out,
	output pdp_adv_t pullup_current_sel,
	// Power and monitoring controls
	output logic vbus_en,
	output logic vconn_a_en,
	output logic vconn_b_en,
	output logic monitor_a,
	output logic monitor_b,
	output logic orient_b,
	output pdp_att_t attach_state,
	// Status flags
	output logic attach_flag,
	output logic detach_flag,
	input wire logic attach_clear,
	input wire logic detach_clear,
	// Transmit bit stream
	input wire logic tx_bit_valid,
	input wire logic tx_bit,
	input wire logic tx_bit_last,
	output logic tx_bit_ready,
	output logic tx_done,
	// Receive bit stream
	output logic rx_bit_valid,
	output logic rx_bit,
	output logic rx_frame_end,
	output logic rx_busy
);
	pdp_class_t cls_a;
	pdp_class_t cls_b;
	logic rx_a;
	logic rx_b;
	pdp_att_t next_att;
	logic next_orient;
	pdp_att_t fresh_att;
	logic fresh_orient;
	pdp_tx_t tx_state;
	logic [CNT_W-1:0] tx_cnt;
	logic tx_level;
	logic tx_oe;
	logic cur_bit;
	logic cur_last;
	logic rx_prev;
	logic [CNT_W-1:0] rx_cnt;
	logic rx_half_seen;
	logic [1:0] tx_oe_hist;

	pdp_line_sense u_sense_a (
		.clock(clock),
		.rst_n(rst_n),
		.below_rd(line_a_below_rd),
		.below_ra(line_a_below_ra),
		.rx_raw(line_a_rx),
		.line_class(cls_a),
		.rx_level(rx_a)
	);

	pdp_line_sense u_sense_b (
		.clock(clock),
		.rst_n(rst_n),
		.below_rd(line_b_below_rd),
		.below_ra(line_b_below_ra),
		.rx_raw(line_b_rx),
		.line_class(cls_b),
		.rx_level(rx_b)
	);

	// Attach decode
	wire a_rd = (cls_a == CLS_RD);
	wire b_rd = (cls_b == CLS_RD);
	wire a_ra = (cls_a == CLS_RA);
	wire b_ra = (cls_b == CLS_RA);
	wire a_open = (cls_a == CLS_OPEN);
	wire b_open = (cls_b == CLS_OPEN);
	wire pdp_class_t cls_sel = orient_b ? cls_b : cls_a;
	wire pdp_class_t cls_other = orient_b ? cls_a : cls_b;
	wire link_up = (attach_state == ST_SINK) || (attach_state == ST_CABLE_SINK);

	always_comb begin
		fresh_att = ST_IDLE;
		fresh_orient = 1'b0;
		if (a_rd && b_rd) begin
			fresh_att = ST_DEBUG;
		end else if (a_ra && b_ra) begin
			fresh_att = ST_AUDIO;
		end else if ((a_rd && b_open) || (a_open && b_rd)) begin
			fresh_att = ST_SINK;
			fresh_orient = b_rd;
		end else if ((a_ra && b_open) || (a_open && b_ra)) begin
			fresh_att = ST_CABLE;
			fresh_orient = a_ra;
		end else if ((a_ra && b_rd) || (a_rd && b_ra)) begin
			fresh_att = ST_CABLE_SINK;
			fresh_orient = b_rd;
		end
	end

	// Orientation names the Rd line, or in cable-only state the open line
	always_comb begin
		next_att = attach_state;
		next_orient = orient_b;
		case (attach_state)
			ST_IDLE: begin
				next_att = fresh_att;
				next_orient = fresh_orient;
			end
			ST_SINK: begin
				if (cls_sel != CLS_RD) begin
					next_att = ST_IDLE;
				end
			end
			ST_CABLE: begin
				if (cls_other != CLS_RA) begin
					next_att = ST_IDLE;
				end else if (cls_sel == CLS_RD) begin
					next_att = ST_CABLE_SINK;
				end
			end
			ST_CABLE_SINK: begin
				if (cls_sel != CLS_RD) begin
					next_att = ST_IDLE;
				end
			end
			ST_DEBUG: begin
				if (!(a_rd && b_rd)) begin
					next_att = ST_IDLE;
				end
			end
			ST_AUDIO: begin
				if (!(a_ra && b_ra)) begin
					next_att = ST_IDLE;
				end
			end
			default: begin
				next_att = ST_IDLE;
			end
		endcase
	end

	wire went_attach = (next_att != attach_state) && (next_att != ST_IDLE);
	wire went_detach = (next_att == ST_IDLE) && (attach_state != ST_IDLE);
	wire next_vbus = (next_att == ST_SINK) || (next_att == ST_CABLE_SINK);
	wire next_vconn = (next_att == ST_CABLE_SINK);
	wire watch_all = (next_att == ST_IDLE) || (next_att == ST_CABLE) ||
		(next_att == ST_DEBUG) || (next_att == ST_AUDIO);

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			attach_state <= ST_IDLE;
			orient_b <= 1'b0;
			vbus_en <= 1'b0;
			vconn_a_en <= 1'b0;
			vconn_b_en <= 1'b0;
			monitor_a <= 1'b1;
			monitor_b <= 1'b1;
		end else begin
			attach_state <= next_att;
			orient_b <= next_orient;
			vbus_en <= next_vbus;
			vconn_a_en <= next_vconn && next_orient;
			vconn_b_en <= next_vconn && !next_orient;
			monitor_a <= watch_all || !next_orient;
			monitor_b <= watch_all || next_orient;
		end
	end

	// Settings go out registered so the analog front end sees clean levels
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			pullup_current_sel <= ADV_DEFAULT;
			tx_peak_level_out <= PEAK_RESET;
		end else begin
			pullup_current_sel <= adv_level;
			tx_peak_level_out <= tx_peak_level;
		end
	end

	// A flag set in the same cycle as its clear stays set
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			attach_flag <= 1'b0;
			detach_flag <= 1'b0;
		end else begin
			attach_flag <= went_attach || (attach_flag && !attach_clear);
			detach_flag <= went_detach || (detach_flag && !detach_clear);
		end
	end

	// Transmitter
	wire half_tick = (tx_cnt == HALF_LAST);
	wire tx_bound = half_tick && ((tx_state == TX_PRE_LOW) || (tx_state == TX_SECOND));
	wire tx_start = (tx_state == TX_IDLE) && tx_bit_valid && link_up && !rx_busy;
	wire tx_take = tx_bound && tx_bit_valid && !cur_last;
	assign tx_bit_ready = tx_take;

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			tx_state <= TX_IDLE;
			tx_cnt <= '0;
			tx_level <= 1'b0;
			tx_oe <= 1'b0;
			cur_bit <= 1'b0;
			cur_last <= 1'b0;
			tx_done <= 1'b0;
		end else begin
			tx_done <= 1'b0;
			tx_cnt <= (tx_state == TX_IDLE || half_tick) ? '0 : tx_cnt + 1'b1;
			case (tx_state)
				TX_IDLE: begin
					if (tx_start) begin
						tx_state <= TX_PRE_LOW;
						tx_level <= 1'b0;
						tx_oe <= 1'b1;
						cur_last <= 1'b0;
					end
				end
				TX_PRE_LOW, TX_SECOND: begin
					if (!link_up) begin
						tx_state <= TX_IDLE;
						tx_oe <= 1'b0;
					end else if (tx_take) begin
						tx_state <= TX_FIRST;
						tx_level <= ~tx_level;
						cur_bit <= tx_bit;
						cur_last <= tx_bit_last;
					end else if (tx_bound) begin
						// An underrun ends the frame rather than stretching a bit
						tx_state <= TX_CLOSE;
						tx_level <= ~tx_level;
					end
				end
				TX_FIRST: begin
					if (!link_up) begin
						tx_state <= TX_IDLE;
						tx_oe <= 1'b0;
					end else if (half_tick) begin
						tx_state <= TX_SECOND;
						tx_level <= tx_level ^ cur_bit;
					end
				end
				TX_CLOSE: begin
					if (half_tick) begin
						tx_state <= TX_IDLE;
						tx_oe <= 1'b0;
						tx_level <= 1'b0;
						tx_done <= 1'b1;
					end
				end
				default: begin
					tx_state <= TX_IDLE;
					tx_oe <= 1'b0;
				end
			endcase
		end
	end

	// Only the oriented line is ever driven
	assign config_line_a_o = tx_level;
	assign config_line_b_o = tx_level;
	assign config_line_a_oe = tx_oe && !orient_b;
	assign config_line_b_oe = tx_oe && orient_b;

	// Receiver
	wire rx_line = orient_b ? rx_b : rx_a;
	// The receive path lags the driver by two flops, so our own release is not an edge
	wire rx_edge = (rx_line != rx_prev) && !tx_oe && !(|tx_oe_hist) && link_up;
	wire rx_short = (rx_cnt <= SHORT_MAX);
	wire rx_timeout = rx_busy && (rx_cnt == IDLE_MAX);

	// The first edge seen only starts timing, so a lost leading edge costs only the first bit
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			rx_prev <= 1'b0;
			tx_oe_hist <= 2'h0;
			rx_cnt <= '0;
			rx_busy <= 1'b0;
			rx_half_seen <= 1'b0;
			rx_bit_valid <= 1'b0;
			rx_bit <= 1'b0;
			rx_frame_end <= 1'b0;
		end else begin
			rx_prev <= rx_line;
			tx_oe_hist <= {tx_oe_hist[0], tx_oe};
			rx_bit_valid <= 1'b0;
			rx_frame_end <= 1'b0;
			if (rx_edge) begin
				rx_cnt <= '0;
				rx_busy <= 1'b1;
				if (!rx_busy) begin
					rx_half_seen <= 1'b0;
				end else if (!rx_short) begin
					rx_bit_valid <= 1'b1;
					rx_bit <= 1'b0;
					rx_half_seen <= 1'b0;
				end else if (rx_half_seen) begin
					rx_bit_valid <= 1'b1;
					rx_bit <= 1'b1;
					rx_half_seen <= 1'b0;
				end else begin
					rx_half_seen <= 1'b1;
				end
			end else if (rx_timeout || (rx_busy && !link_up)) begin
				rx_busy <= 1'b0;
				rx_half_seen <= 1'b0;
				rx_frame_end <= 1'b1;
			end else if (rx_busy) begin
				rx_cnt <= rx_cnt + 1'b1;
			end
		end
	end
endmodule

// ===== design/pdp_pkg.sv
// Purpose: Shared constants and types for the power-delivery line PHY and attach logic
// Assumes: 100 MHz clock, nominal 300 kbit/s biphase mark signalling
// Notes: Class codes feed both the line sense and the attach state logic
package pdp_pkg;
	localparam int CLK_PERIOD_NS = 10;
	localparam int BIT_PERIOD_NS = 3333;
	localparam int HALF_BIT_CYCLES = BIT_PERIOD_NS / (2 * CLK_PERIOD_NS);
	localparam int SHORT_LIMIT_CYCLES = (3 * HALF_BIT_CYCLES) / 2;
	localparam int IDLE_LIMIT_CYCLES = 4 * HALF_BIT_CYCLES;
	localparam int CNT_W = 10;
	localparam logic [CNT_W-1:0] HALF_LAST = CNT_W'(HALF_BIT_CYCLES - 1);
	localparam logic [CNT_W-1:0] SHORT_MAX = CNT_W'(SHORT_LIMIT_CYCLES);
	localparam logic [CNT_W-1:0] IDLE_MAX = CNT_W'(IDLE_LIMIT_CYCLES);
	localparam int PEAK_W = 4;
	localparam logic [PEAK_W-1:0] PEAK_RESET = 4'h8;

	typedef enum logic [1:0] {
		ADV_DEFAULT = 2'h0,
		ADV_1A5 = 2'h1,
		ADV_3A0 = 2'h2
	} pdp_adv_t;

	typedef enum logic [1:0] {
		CLS_OPEN = 2'h0,
		CLS_RA = 2'h1,
		CLS_RD = 2'h2
	} pdp_class_t;

	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_SINK = 6'h02,
		ST_CABLE = 6'h04,
		ST_CABLE_SINK = 6'h08,
		ST_DEBUG = 6'h10,
		ST_AUDIO = 6'h20
	} pdp_att_t;

	typedef enum logic [4:0] {
		TX_IDLE = 5'h01,
		TX_PRE_LOW = 5'h02,
		TX_FIRST = 5'h04,
		TX_SECOND = 5'h08,
		TX_CLOSE = 5'h10
	} pdp_tx_t;
endpackage

// ===== verification/pdp_far_end.sv
// Purpose: Far port model with terminations and a sender on line b
// Assumes: Ra trips both comparators; undriven line reads its bias high
// Notes: Sends only while the device driver is off
`timescale 1ns/1ps
module pdp_far_end
	import pdp_pkg::*;
(
	// Clock and terminations
	input wire logic clock,
	input wire pdp_class_t cls_a,
	input wire pdp_class_t cls_b,
	// Device drivers
	input wire logic config_line_a_o,
	input wire logic config_line_a_oe,
	input wire logic config_line_b_o,
	input wire logic config_line_b_oe,
	// Comparators and levels
	output logic line_a_below_rd,
	output logic line_a_below_ra,
	output logic line_a_rx,
	output logic line_b_below_rd,
	output logic line_b_below_ra,
	output logic line_b_rx
);
	logic far_oe = 1'b0;
	logic far_o = 1'b1;
	assign line_a_below_rd = cls_a != CLS_OPEN;
	assign line_a_below_ra = cls_a == CLS_RA;
	assign line_b_below_rd = cls_b != CLS_OPEN;
	assign line_b_below_ra = cls_b == CLS_RA;
	// Bias returns once nobody drives
	assign line_a_rx = config_line_a_oe ? config_line_a_o : 1'b1;
	assign line_b_rx = config_line_b_oe ? config_line_b_o : (far_oe ? far_o : 1'b1);
	task automatic send(input logic [7:0] bits, input logic skip);
		@(posedge clock);
		far_oe <= 1'b1;
		far_o <= skip;
		for (int i = 7; i >= 0; i--) begin
			repeat (166) @(posedge clock);
			if (bits[i]) far_o <= ~far_o;
			repeat (166) @(posedge clock);
			far_o <= ~far_o;
		end
		repeat (166) @(posedge clock);
		far_oe <= 1'b0;
	endtask
endmodule

// ===== verification/pdp_phy_attach_assertions.sv
// Purpose: Port-level checks of the line PHY and attach logic
// Assumes: One clock domain, synchronous active-low reset
// Notes: Sees only the top module's ports
`timescale 1ns/1ps
module pdp_phy_attach_assertions
	import pdp_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Settings
	input wire pdp_adv_t adv_level,
	input wire logic [PEAK_W-1:0] tx_peak_level,
	input wire logic [PEAK_W-1:0] tx_peak_level_out,
	input wire pdp_adv_t pullup_current_sel,
	// Drivers
	input wire logic config_line_a_o,
	input wire logic config_line_a_oe,
	input wire logic config_line_b_oe,
	input wire logic rx_busy,
	// Attach outputs
	input wire logic vbus_en,
	input wire logic vconn_a_en,
	input wire logic vconn_b_en,
	input wire logic monitor_a,
	input wire logic monitor_b,
	input wire logic orient_b,
	input wire pdp_att_t attach_state,
	input wire logic attach_flag
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	a_one_driver: assert property (!(config_line_a_oe && config_line_b_oe))
		else $error("both drivers on");
	a_idle_safe: assert property (attach_state == ST_IDLE |->
		!vbus_en && !vconn_a_en && !vconn_b_en && monitor_a && monitor_b)
		else $error("idle not safe");
	a_sink_power: assert property (attach_state == ST_SINK |-> vbus_en && !vconn_a_en
		&& !vconn_b_en && monitor_b == orient_b && monitor_a != orient_b)
		else $error("sink power wrong");
	a_cable_off: assert property (attach_state == ST_CABLE |->
		!vbus_en && !vconn_a_en && !vconn_b_en && monitor_a && monitor_b)
		else $error("cable power wrong");
	a_vconn_ra: assert property (attach_state == ST_CABLE_SINK |-> vbus_en
		&& vconn_a_en == orient_b && vconn_b_en != orient_b && monitor_b == orient_b)
		else $error("vconn line wrong");
	a_tx_low: assert property ($rose(config_line_a_oe || config_line_b_oe) |->
		!config_line_a_o && !$past(rx_busy))
		else $error("bad transmit start");
	a_peak_copy: assert property ($past(rst_n) |-> tx_peak_level_out ==
		$past(tx_peak_level) && pullup_current_sel == $past(adv_level))
		else $error("setting not applied");
	a_attach_set: assert property (attach_state == ST_IDLE ##1 attach_state != ST_IDLE
		|-> attach_flag)
		else $error("attach flag missing");
endmodule
bind pdp_phy_attach pdp_phy_attach_assertions u_chk (.*);

// ===== verification/pdp_phy_attach_tb_top.sv
// Purpose: Self-checking bench for the line PHY and attach logic
// Assumes: Half bit of 166 cycles at 100 MHz
// Notes: Far model sends on line b only
`timescale 1ns/1ps
module pdp_phy_attach_tb_top;
	import pdp_pkg::*;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	pdp_adv_t adv_level = ADV_DEFAULT;
	pdp_adv_t pullup_current_sel;
	pdp_class_t cls_a = CLS_OPEN;
	pdp_class_t cls_b = CLS_OPEN;
	pdp_att_t attach_state;
	logic [3:0] tx_peak_level = 4'h0;
	logic [3:0] tx_peak_level_out;
	logic attach_clear = 1'b0, detach_clear = 1'b0;
	logic tx_bit_valid = 1'b0, tx_bit = 1'b0, tx_bit_last = 1'b0;
	logic line_a_below_rd, line_a_below_ra, line_a_rx, line_b_below_rd, line_b_below_ra;
	logic line_b_rx, config_line_a_o, config_line_a_oe, config_line_b_o, config_line_b_oe;
	logic vbus_en, vconn_a_en, vconn_b_en, monitor_a, monitor_b, orient_b, attach_flag;
	logic detach_flag, tx_bit_ready, tx_done, rx_bit_valid, rx_bit, rx_frame_end, rx_busy;
	logic last_o = 1'b0, fe = 1'b0;
	logic [7:0] rx_sh = 8'h00;
	int n_mismatch = 0, samples_checked = 0, n_edge = 0, rx_n = 0;
	logic [15:0] tbl [9] = '{16'h0046, 16'h80A4, 16'h20A3, 16'h4107, 16'h1106, 16'h6233,
		16'h922C, 16'hA406, 16'h5806};
	always #5 clock = ~clock;
	pdp_phy_attach u_pdp_phy_attach (.*);
	pdp_far_end u_pdp_far_end (.*);
	always @(posedge clock) begin
		last_o <= config_line_a_o;
		if (config_line_a_oe === 1'b1 && config_line_a_o !== last_o) n_edge <= n_edge + 1;
		if (rx_bit_valid === 1'b1) rx_sh <= {rx_sh[6:0], rx_bit};
		if (rx_bit_valid === 1'b1) rx_n <= rx_n + 1;
		if (rx_frame_end === 1'b1) fe <= 1'b1;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
	endtask
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic summarize;
		$display("mismatches %0d of %0d checks", n_mismatch, samples_checked);
		if (n_mismatch == 0 && samples_checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic t_set;
		for (int i = 0; i < 3; i++) begin
			adv_level <= pdp_adv_t'(i);
			tx_peak_level <= 4'(3 * i + 1);
			tick(3);
			chk("pullup", pullup_current_sel, 16'(i));
			chk("peak", tx_peak_level_out, 16'(3 * i + 1));
		end
		$display("test settings done");
	endtask
	task automatic t_attach;
		logic [15:0] m;
		for (int i = 0; i < 9; i++) begin
			{attach_clear, detach_clear} <= 2'h3;
			tick(1);
			{attach_clear, detach_clear} <= 2'h0;
			{cls_a, cls_b} <= tbl[i][15:12];
			tick(8);
			// Accessory power is left open, so only state and watch lines count
			m = (i < 7) ? 16'h0FFF : 16'h0FC6;
			chk("attach", {attach_state, vbus_en, vconn_a_en, vconn_b_en, monitor_a,
				monitor_b, orient_b} & m, tbl[i] & m);
			chk("attach flag", attach_flag, 16'(i > 0));
			{cls_a, cls_b} <= 4'h0;
			tick(8);
			chk("detach flag", detach_flag, 16'(i > 0));
		end
		{cls_a, cls_b} <= 4'h4;
		tick(8);
		cls_b <= CLS_RD;
		tick(8);
		chk("cable to sink", attach_state, ST_CABLE_SINK);
		$display("test attach done");
	endtask
	task automatic t_tx;
		int k, e0;
		{cls_a, cls_b} <= 4'h8;
		tick(12);
		e0 = n_edge;
		for (int i = 0; i < 3; i++) begin
			tx_bit_valid <= 1'b1;
			tx_bit <= i != 1;
			tx_bit_last <= i == 2;
			k = 0;
			do begin
				tick(1);
				k++;
			end while (tx_bit_ready !== 1'b1 && k < 1000);
		end
		tx_bit_valid <= 1'b0;
		k = 0;
		while (tx_done !== 1'b1 && k < 1000) begin
			tick(1);
			k++;
		end
		chk("done", 16'(k < 1000), 1);
		chk("edges", 16'(n_edge - e0), 6);
		tick(1);
		chk("drivers", {config_line_a_oe, config_line_b_oe}, 0);
		$display("test transmit done");
	endtask
	task automatic t_rx(input logic [7:0] bits, input logic skip);
		int n0;
		logic [7:0] m;
		{cls_a, cls_b} <= 4'h2;
		tick(12);
		n0 = rx_n;
		fe <= 1'b0;
		m = skip ? 8'h7F : 8'hFF;
		u_pdp_far_end.send(bits, skip);
		tick(900);
		chk("rx count", 16'(rx_n - n0), skip ? 16'h7 : 16'h8);
		chk("rx bits", rx_sh & m, bits & m);
		chk("frame end", fe, 1);
		$display("test receive done");
	endtask
	initial begin
		#200us;
		n_mismatch++;
		summarize;
	end
	initial begin
		tick(4);
		chk("reset peak", tx_peak_level_out, PEAK_RESET);
		chk("reset idle", {attach_state, vbus_en, monitor_a, monitor_b, attach_flag},
			{ST_IDLE, 4'h6});
		$display("test reset done");
		rst_n <= 1'b1;
		tick(1);
		t_set;
		t_attach;
		t_tx;
		t_rx(8'hB1, 1'b0);
		t_rx(8'h55, 1'b1);
		summarize;
	end
endmodule
